// [inc/btio_pkg.sv]
// constants and types for branch target and implied operand logic
//
// What this block does
// (RQ1) sequential flow adds the instruction byte count to the program counter
// (RQ2) relative branch adds the offset to the following instruction address
// (RQ3) offset is two's complement, bit 7 sign, reach -128 to +127
// (RQ4) offset upper byte is filled with copies of the sign bit
// (RQ5) relative targets serve the relative jump and all conditional branches
// (RQ6) absolute jump and subroutine jump load the 16-bit field directly
// (RQ7) fixed page jump reaches only 0800H through 0FFFH
// (RQ8) vector jump index comes from instruction bits 1 to 5
// (RQ9) vector table lives at 40H to 7FH, entries point anywhere
// (RQ10) register-indirect jump copies the working word register into the counter
// (RQ11) multiply takes the working byte register, writes product to word register
// (RQ12) divide reads dividend from word register, writes quotient back there
// (RQ13) decimal fixes work on the working byte register
// (RQ14) digit rotates use the working byte register as source and destination
// (RQ15) multiply is 8 by 8 unsigned giving a 16-bit result
// (RQ16) fixed page target is 00001 above the 11-bit field
// (RQ17) vector entry at 40H plus twice index, read low byte first
package btio_pkg;

  // ****************************************
  // widths and fixed values
  // ****************************************
  localparam int unsigned        BTIO_PC_W      = 16;
  localparam logic [15:0]        BTIO_PC_RESET  = 16'h0000;
  localparam logic [15:0]        BTIO_VEC_BASE  = 16'h0040;
  localparam logic [15:0]        BTIO_VEC_LAST  = 16'h007f;
  localparam logic [4:0]         BTIO_PAGE_HIGH = 5'h01;
  localparam int unsigned        BTIO_IDX_LSB   = 1;
  localparam int unsigned        BTIO_IDX_MSB   = 5;
  localparam int unsigned        BTIO_SIGN_BIT  = 7;
  localparam logic [15:0]        BTIO_DIV0_QUOT = 16'hffff;

  // ****************************************
  // operation kinds from the decoder
  // ****************************************
  typedef enum logic [3:0] {
    BTIO_OP_SEQ,
    BTIO_OP_REL_JUMP,
    BTIO_OP_COND_REL,
    BTIO_OP_ABS_JUMP,
    BTIO_OP_ABS_CALL,
    BTIO_OP_FIXED_PAGE,
    BTIO_OP_VECTOR,
    BTIO_OP_REG_JUMP,
    BTIO_OP_MUL,
    BTIO_OP_DIV,
    BTIO_OP_DEC_ADD,
    BTIO_OP_DEC_SUB,
    BTIO_OP_ROT_R,
    BTIO_OP_ROT_L
  } btio_op_t;

endpackage : btio_pkg

// [inc/btio_impl_if.sv]
// carrier between the sequencer and the implied operand unit
interface btio_impl_if;
  import btio_pkg::*;
  btio_op_t    kind;
  logic [7:0]  byte_val;
  logic [7:0]  opnd_val;
  logic [15:0] word_val;
  logic [15:0] result;
  logic        rd_byte;
  logic        rd_word;
  logic        wr_byte;
  logic        wr_word;

  modport core (output kind, byte_val, opnd_val, word_val,
                input  result, rd_byte, rd_word, wr_byte, wr_word);
  modport unit (input  kind, byte_val, opnd_val, word_val,
                output result, rd_byte, rd_word, wr_byte, wr_word);
endinterface : btio_impl_if

// [rtl/btio_implied_unit.sv]
// implied operand selection, multiply and divide datapath
module btio_implied_unit
  import btio_pkg::*;
(
  btio_impl_if.unit io
);

  logic [16:0] rem_w;
  logic [15:0] quot_w;

  // ****************************************
  // restoring divide, word by byte
  // ****************************************
  always_comb begin
    rem_w  = 17'h00000;
    quot_w = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      rem_w = {rem_w[15:0], io.word_val[i]};
      if (rem_w >= {9'h000, io.opnd_val}) begin
        rem_w     = rem_w - {9'h000, io.opnd_val};
        quot_w[i] = 1'b1;
      end
    end
  end

  // ****************************************
  // operand steering
  // ****************************************
  always_comb begin
    io.result  = 16'h0000;
    io.rd_byte = 1'b0;
    io.rd_word = 1'b0;
    io.wr_byte = 1'b0;
    io.wr_word = 1'b0;
    case (io.kind)
      BTIO_OP_MUL: begin
        io.rd_byte = 1'b1;                                   // [RQ11]
        io.wr_word = 1'b1;                                   // [RQ11]
        io.result  = 16'(io.byte_val) * 16'(io.opnd_val);    // [RQ15]
      end
      BTIO_OP_DIV: begin
        io.rd_word = 1'b1;                                   // [RQ12]
        io.wr_word = 1'b1;                                   // [RQ12]
        // zero divisor: all-ones quotient, no trap here
        io.result  = (io.opnd_val == 8'h00) ? BTIO_DIV0_QUOT : quot_w; // [RQ12]
      end
      BTIO_OP_DEC_ADD, BTIO_OP_DEC_SUB: begin
        io.rd_byte = 1'b1;                                   // [RQ13]
        io.wr_byte = 1'b1;                                   // [RQ13]
        io.result  = {8'h00, io.byte_val};
      end
      BTIO_OP_ROT_R, BTIO_OP_ROT_L: begin
        io.rd_byte = 1'b1;                                   // [RQ14]
        io.wr_byte = 1'b1;                                   // [RQ14]
        io.result  = {8'h00, io.byte_val};
      end
      default: begin
        io.result = 16'h0000;
      end
    endcase
  end

endmodule : btio_implied_unit

// [rtl/btio_next_pc.sv]
// program counter next address, branch target and implied operand sequencer
module btio_next_pc
  import btio_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // decoder request
  input  wire logic        req_valid_in,
  input  wire btio_op_t    req_op_in,
  input  wire logic [2:0]  req_len_in,
  input  wire logic [7:0]  req_opcode_in,
  input  wire logic [7:0]  req_rel_offset_in,
  input  wire logic [15:0] req_abs_target_in,
  input  wire logic [10:0] req_page_target_in,
  input  wire logic        req_cond_taken_in,
  // working registers
  input  wire logic [7:0]  work_byte_in,
  input  wire logic [7:0]  work_opnd_in,
  input  wire logic [15:0] work_word_in,
  // program memory read port
  output logic             mem_rd_out,
  output logic [15:0]      mem_addr_out,
  input  wire logic        mem_valid_in,
  input  wire logic [7:0]  mem_data_in,
  // counter and status
  output logic [15:0]      pc_out,
  output logic             pc_load_out,
  output logic             busy_out,
  // implied operand results
  output logic             impl_valid_out,
  output logic             impl_rd_byte_out,
  output logic             impl_rd_word_out,
  output logic             impl_wr_byte_out,
  output logic             impl_wr_word_out,
  output logic [15:0]      impl_result_out
);

  typedef enum logic [1:0] {
    BTIO_ST_IDLE,
    BTIO_ST_VEC_LO,
    BTIO_ST_VEC_HI
  } btio_state_t;

  btio_state_t state_q;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic        load_d;
  logic [15:0] next_seq;
  logic [15:0] rel_target;
  logic [15:0] sext_off;
  logic [15:0] vec_addr;
  logic [4:0]  vec_idx;
  logic [7:0]  vec_lo_q;
  logic        take;
  logic        is_impl;

  btio_impl_if impl_bus ();

  btio_implied_unit u_impl (
    .io (impl_bus.unit)
  );

  assign impl_bus.kind     = req_op_in;
  assign impl_bus.byte_val = work_byte_in;
  assign impl_bus.opnd_val = work_opnd_in;
  assign impl_bus.word_val = work_word_in;

  // ****************************************
  // target arithmetic
  // ****************************************
  assign take       = req_valid_in && (state_q == BTIO_ST_IDLE);
  assign next_seq   = pc_q + {13'h0000, req_len_in};                      // [RQ1]
  assign sext_off   = {{8{req_rel_offset_in[BTIO_SIGN_BIT]}}, req_rel_offset_in}; // [RQ3] [RQ4]
  // wraps modulo 64k, no carry out kept
  assign rel_target = next_seq + sext_off;                                 // [RQ2]
  assign vec_idx    = req_opcode_in[BTIO_IDX_MSB:BTIO_IDX_LSB];            // [RQ8]
  assign vec_addr   = BTIO_VEC_BASE + {10'h000, vec_idx, 1'b0};            // [RQ9] [RQ17]
  assign is_impl    = impl_bus.rd_byte || impl_bus.rd_word;

  always_comb begin
    pc_d   = pc_q;
    load_d = 1'b0;
    case (req_op_in)
      BTIO_OP_REL_JUMP: begin
        pc_d   = rel_target;                                               // [RQ5]
        load_d = 1'b1;
      end
      BTIO_OP_COND_REL: begin
        pc_d   = req_cond_taken_in ? rel_target : next_seq;                // [RQ5]
        load_d = req_cond_taken_in;
      end
      BTIO_OP_ABS_JUMP, BTIO_OP_ABS_CALL: begin
        pc_d   = req_abs_target_in;                                        // [RQ6]
        load_d = 1'b1;
      end
      BTIO_OP_FIXED_PAGE: begin
        pc_d   = {BTIO_PAGE_HIGH, req_page_target_in};                     // [RQ7] [RQ16]
        load_d = 1'b1;
      end
      BTIO_OP_REG_JUMP: begin
        pc_d   = work_word_in;                                             // [RQ10]
        load_d = 1'b1;
      end
      default: begin
        pc_d   = next_seq;                                                 // [RQ1]
        load_d = 1'b0;
      end
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= BTIO_ST_IDLE;
    end else begin
      case (state_q)
        BTIO_ST_IDLE: begin
          if (take && req_op_in == BTIO_OP_VECTOR) begin
            state_q <= BTIO_ST_VEC_LO;
          end
        end
        BTIO_ST_VEC_LO: begin
          if (mem_valid_in) begin
            state_q <= BTIO_ST_VEC_HI;
          end
        end
        BTIO_ST_VEC_HI: begin
          if (mem_valid_in) begin
            state_q <= BTIO_ST_IDLE;
          end
        end
        default: begin
          state_q <= BTIO_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // vector table fetch
  // ****************************************
  // one read outstanding at a time keeps the byte order unambiguous
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_rd_out   <= 1'b0;
      mem_addr_out <= 16'h0000;
      vec_lo_q     <= 8'h00;
    end else begin
      mem_rd_out <= 1'b0;
      if (take && req_op_in == BTIO_OP_VECTOR) begin
        mem_rd_out   <= 1'b1;
        mem_addr_out <= vec_addr;                                          // [RQ17]
      end else if (state_q == BTIO_ST_VEC_LO && mem_valid_in) begin
        vec_lo_q     <= mem_data_in;                                       // [RQ17]
        mem_rd_out   <= 1'b1;
        mem_addr_out <= mem_addr_out + 16'h0001;
      end
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_q        <= BTIO_PC_RESET;
      pc_load_out <= 1'b0;
    end else begin
      pc_load_out <= 1'b0;
      if (state_q == BTIO_ST_VEC_HI && mem_valid_in) begin
        pc_q        <= {mem_data_in, vec_lo_q};                            // [RQ8] [RQ9]
        pc_load_out <= 1'b1;
      end else if (take && req_op_in != BTIO_OP_VECTOR) begin
        pc_q        <= pc_d;
        pc_load_out <= load_d;
      end
    end
  end

  assign pc_out = pc_q;

  // ****************************************
  // busy and implied results
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (take && req_op_in == BTIO_OP_VECTOR) ||
                  (state_q == BTIO_ST_VEC_LO) ||
                  (state_q == BTIO_ST_VEC_HI && !mem_valid_in);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      impl_valid_out   <= 1'b0;
      impl_rd_byte_out <= 1'b0;
      impl_rd_word_out <= 1'b0;
      impl_wr_byte_out <= 1'b0;
      impl_wr_word_out <= 1'b0;
      impl_result_out  <= 16'h0000;
    end else begin
      impl_valid_out   <= take && is_impl;
      impl_rd_byte_out <= take && impl_bus.rd_byte;                        // [RQ11] [RQ13] [RQ14]
      impl_rd_word_out <= take && impl_bus.rd_word;                        // [RQ12]
      impl_wr_byte_out <= take && impl_bus.wr_byte;                        // [RQ13] [RQ14]
      impl_wr_word_out <= take && impl_bus.wr_word;                        // [RQ11] [RQ12]
      if (take && is_impl) begin
        impl_result_out <= impl_bus.result;                                // [RQ15]
      end
    end
  end

endmodule : btio_next_pc

// [testbench/btio_next_pc_sva.sv]
// assertions on the next address and implied operand ports
module btio_next_pc_sva
  import btio_pkg::*;
(
  // watched ports
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        req_valid_in,
  input wire btio_op_t    req_op_in,
  input wire logic [2:0]  req_len_in,
  input wire logic [7:0]  req_opcode_in,
  input wire logic [7:0]  req_rel_offset_in,
  input wire logic [15:0] req_abs_target_in,
  input wire logic [10:0] req_page_target_in,
  input wire logic        req_cond_taken_in,
  input wire logic [7:0]  work_byte_in,
  input wire logic [7:0]  work_opnd_in,
  input wire logic [15:0] work_word_in,
  input wire logic        mem_rd_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic        pc_load_out,
  input wire logic [15:0] pc_out,
  input wire logic        busy_out,
  input wire logic        impl_rd_byte_out,
  input wire logic        impl_rd_word_out,
  input wire logic        impl_wr_byte_out,
  input wire logic        impl_wr_word_out,
  input wire logic [15:0] impl_result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic        take;
  logic [15:0] step;
  assign take = req_valid_in && !busy_out;
  assign step = {13'h0000, req_len_in};
  sequence s_vec_take;
    take && req_op_in == BTIO_OP_VECTOR;
  endsequence
  sequence s_first_read;
    mem_rd_out && busy_out;
  endsequence
  seq_advance_a:
    assert property (take && req_op_in == BTIO_OP_SEQ |=> !pc_load_out
      && pc_out == $past(pc_out) + $past(step)) else $error("pc step wrong");
  rel_target_a:
    assert property (take && (req_op_in == BTIO_OP_REL_JUMP || req_op_in == BTIO_OP_COND_REL
      && req_cond_taken_in) |=> pc_load_out && pc_out == $past(pc_out) + $past(step)
      + {{8{$past(req_rel_offset_in[7])}}, $past(req_rel_offset_in)}) else $error("rel bad");
  cond_skip_a:
    assert property (take && req_op_in == BTIO_OP_COND_REL && !req_cond_taken_in |=>
      !pc_load_out && pc_out == $past(pc_out) + $past(step)) else $error("skip bad");
  abs_load_a:
    assert property (take && req_op_in inside {BTIO_OP_ABS_JUMP, BTIO_OP_ABS_CALL} |=>
      pc_load_out && pc_out == $past(req_abs_target_in)) else $error("abs bad");
  page_range_a:
    assert property (take && req_op_in == BTIO_OP_FIXED_PAGE |=>
      pc_out == {5'h01, $past(req_page_target_in)}) else $error("page bad");
  reg_jump_a:
    assert property (take && req_op_in == BTIO_OP_REG_JUMP |=>
      pc_out == $past(work_word_in)) else $error("reg jump bad");
  vec_entry_a:
    assert property (s_vec_take |=> s_first_read ##0
      mem_addr_out == {10'h001, $past(req_opcode_in[5:1]), 1'b0}) else $error("entry bad");
  vec_window_a:
    assert property (mem_rd_out |-> mem_addr_out inside {[16'h0040:16'h007f]})
      else $error("table range bad");
  mul_product_a:
    assert property (take && req_op_in == BTIO_OP_MUL |=> impl_rd_byte_out && impl_wr_word_out
      && impl_result_out == 16'($past(work_byte_in)) * 16'($past(work_opnd_in)))
      else $error("product bad");
  div_quot_a:
    assert property (take && req_op_in == BTIO_OP_DIV && work_opnd_in != 8'h00 |=>
      impl_rd_word_out && impl_wr_word_out
      && impl_result_out == $past(work_word_in) / 16'($past(work_opnd_in)))
      else $error("quotient bad");
  byte_ops_a:
    assert property (take && req_op_in inside {[BTIO_OP_DEC_ADD:BTIO_OP_ROT_L]} |=>
      impl_rd_byte_out && impl_wr_byte_out && !impl_wr_word_out) else $error("byte sel bad");
endmodule : btio_next_pc_sva

bind btio_next_pc btio_next_pc_sva u_btio_next_pc_sva (.*);

// [testbench/btio_mem_model.sv]
// program memory model answering vector table reads
module btio_mem_model (
  // memory port
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        slow_in,
  input  wire logic        rd_in,
  input  wire logic [15:0] addr_in,
  output logic             valid_out,
  output logic [7:0]       data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q;
  // idle data toggles so a stale byte is never mistaken for a good one
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_q <= 3'h0;
      valid_out <= 1'b0;
      data_out <= 8'h00;
    end else if (wait_q == 3'h1) begin
      wait_q <= 3'h0;
      valid_out <= 1'b1;
      data_out <= addr_in[7:0] ^ 8'ha5;
    end else begin
      wait_q <= rd_in ? (slow_in ? 3'h4 : 3'h1) : wait_q - 3'(wait_q != 3'h0);
      valid_out <= 1'b0;
      data_out <= ~data_out;
    end
  end
endmodule : btio_mem_model

// [testbench/testbench.sv]
// self-checking bench for the next address and implied operand sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import btio_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, req_valid_in = 1'b0, req_cond_taken_in = 1'b0;
  logic mem_valid_in, mem_rd_out, pc_load_out, busy_out, impl_valid_out, slow = 1'b0;
  logic impl_rd_byte_out, impl_rd_word_out, impl_wr_byte_out, impl_wr_word_out;
  btio_op_t req_op_in = BTIO_OP_SEQ;
  logic [2:0] req_len_in = 3'h0;
  logic [7:0] req_opcode_in = 8'h00, req_rel_offset_in = 8'h00, mem_data_in;
  logic [7:0] work_byte_in = 8'h00, work_opnd_in = 8'h00;
  logic [10:0] req_page_target_in = 11'h000;
  logic [15:0] req_abs_target_in = 16'h0000, work_word_in = 16'h0000;
  logic [15:0] mem_addr_out, pc_out, impl_result_out, pc = 16'h0000;
  int mismatches = 0, comparisons = 0, cycles = 0;
  btio_next_pc u_btio_next_pc (.*);
  btio_mem_model u_btio_mem_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .slow_in(slow),
    .rd_in(mem_rd_out), .addr_in(mem_addr_out), .valid_out(mem_valid_in), .data_out(mem_data_in));
  always #12.5 clk_in = ~clk_in;
  // ****************
  // shared tasks
  // ****************
  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic go(btio_op_t o, logic [2:0] n, logic [15:0] v, logic c, logic [7:0] b, d);
    @(posedge clk_in);
    {req_op_in, req_len_in, req_valid_in, req_cond_taken_in} <= {o, n, 1'b1, c};
    {req_rel_offset_in, req_opcode_in, req_page_target_in} <= {v[7:0], v[7:0], v[10:0]};
    {req_abs_target_in, work_word_in, work_byte_in, work_opnd_in} <= {v, v, b, d};
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    #1;
  endtask : go
  task automatic step(input logic [15:0] e, input logic ld);
    chk("pc_out", e, pc_out);
    chk("pc_load_out", {15'h0000, ld}, {15'h0000, pc_load_out});
    pc = e;
  endtask : step
  task automatic ichk(input logic [15:0] e, input logic [3:0] sel);
    chk("impl_result_out", e, impl_result_out);
    chk("impl_valid_out", 16'h0001, {15'h0000, impl_valid_out});
    chk("impl_select", {12'h000, sel}, {12'h000, impl_rd_byte_out, impl_rd_word_out,
      impl_wr_byte_out, impl_wr_word_out});
    step(pc + 16'h0002, 1'b0);
  endtask : ichk
  // ****************
  // scenarios
  // ****************
  task automatic t_flow;
    for (int n = 1; n <= 4; n++) begin
      go(BTIO_OP_SEQ, 3'(n), 16'h0000, 1'b0, 8'h00, 8'h00);
      step(pc + 16'(n), 1'b0);
      chk("impl_valid_out", 16'h0000, {15'h0000, impl_valid_out});
    end
    go(BTIO_OP_ABS_JUMP, 3'h3, 16'h0100, 1'b0, 8'h00, 8'h00);
    step(16'h0100, 1'b1);
    go(BTIO_OP_REL_JUMP, 3'h2, 16'h0080, 1'b0, 8'h00, 8'h00);
    step(16'h0082, 1'b1);
    go(BTIO_OP_COND_REL, 3'h2, 16'h007f, 1'b1, 8'h00, 8'h00);
    step(16'h0103, 1'b1);
    go(BTIO_OP_COND_REL, 3'h2, 16'h0080, 1'b0, 8'h00, 8'h00);
    step(16'h0105, 1'b0);
    go(BTIO_OP_ABS_CALL, 3'h3, 16'hfffe, 1'b0, 8'h00, 8'h00);
    step(16'hfffe, 1'b1);
    go(BTIO_OP_FIXED_PAGE, 3'h2, 16'hffff, 1'b0, 8'h00, 8'h00);
    step(16'h0fff, 1'b1);
    go(BTIO_OP_FIXED_PAGE, 3'h2, 16'h0000, 1'b0, 8'h00, 8'h00);
    step(16'h0800, 1'b1);
    go(BTIO_OP_REG_JUMP, 3'h1, 16'hbeef, 1'b0, 8'h00, 8'h00);
    step(16'hbeef, 1'b1);
  endtask : t_flow
  task automatic t_vec(input logic [4:0] ix, input logic sl);
    logic [7:0] a;
    a = 8'h40 + {2'b00, ix, 1'b0};
    slow = sl;
    go(BTIO_OP_VECTOR, 3'h1, {10'h003, ix, 1'b1}, 1'b0, 8'h00, 8'h00);
    repeat (40) if (pc_load_out !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    step({(a + 8'h01) ^ 8'ha5, a ^ 8'ha5}, 1'b1);
  endtask : t_vec
  task automatic t_impl;
    btio_op_t ops[4] = '{BTIO_OP_DEC_ADD, BTIO_OP_DEC_SUB, BTIO_OP_ROT_R, BTIO_OP_ROT_L};
    go(BTIO_OP_MUL, 3'h2, 16'h0000, 1'b0, 8'hff, 8'hfe);
    ichk(16'hfd02, 4'b1001);
    go(BTIO_OP_DIV, 3'h2, 16'h0064, 1'b0, 8'h00, 8'h07);
    ichk(16'h000e, 4'b0101);
    go(BTIO_OP_DIV, 3'h2, 16'h1234, 1'b0, 8'h00, 8'h00);
    ichk(16'hffff, 4'b0101);
    for (int i = 0; i < 4; i++) begin
      go(ops[i], 3'h2, 16'h0000, 1'b0, 8'h3c + 8'(i), 8'h00);
      ichk({8'h00, 8'h3c + 8'(i)}, 4'b1010);
    end
  endtask : t_impl
  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_flow();
    t_vec(5'h00, 1'b0);
    t_vec(5'h1f, 1'b1);
    t_impl();
    end_of_test();
  end
endmodule : testbench
